//--- src/dvga_ctrl_host.sv
// dvga_ctrl_host.sv: controller end, drives the gain pins and serial port
// assumes a register master on mclk with one-cycle strobes
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dvga_map.svh"
module dvga_ctrl_host #(
  parameter int DIV = `SCLK_DIV
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output var logic [31:0] rdata,
  // link to the device
  dvga_link_if.host_mp link
);
  import dvga_pkg::*;

  // ********************
  // timing
  // ********************
  localparam int HALF = DIV / 2;
  localparam int SEEN = `DEV_SCLKS * DIV;
  localparam int LAT_W = (`TLP_CYC > SEEN) ? `TLP_CYC : SEEN;
  localparam int PLS_W = (`TPW_CYC > SEEN) ? `TPW_CYC : SEEN;
  localparam int GAP_W = (`TPG_CYC > SEEN) ? `TPG_CYC : SEEN;

  // ********************
  // serial clock divider
  // ********************
  logic [7:0] div_r;
  logic sclk_r;
  wire div_end = (div_r == 8'(HALF - 1));
  wire rise_ev = div_end & ~sclk_r;
  wire fall_ev = div_end & sclk_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (clk_en) begin
      div_r <= div_end ? 8'h00 : div_r + 8'h01;
      if (div_end) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // ********************
  // register decode
  // ********************
  wire wr_ctrl = wr_stb & (addr == `REG_CTRL);
  wire wr_par = wr_stb & (addr == `REG_PAR);
  wire wr_pls = wr_stb & (addr == `REG_PULSE);
  wire wr_spi = wr_stb & (addr == `REG_SPI);
  logic [`CTRL_W-1:0] ctrl_r;
  logic [5:0] g1_r;
  logic [5:0] g2_r;
  logic [15:0] hcnt_r;
  logic [1:0] hold_r;
  spi_st_t spi_st_r;
  pls_st_t pls_st_r;
  logic [7:0] rx_r;
  wire spi_busy = (spi_st_r != SPI_IDLE);
  wire pls_busy = (pls_st_r != PLS_IDLE);
  wire hold_busy = (hcnt_r != 16'h0000);
  wire [31:0] stat_w = {16'h0000, rx_r, 5'h00, hold_busy, pls_busy, spi_busy};
  wire [31:0] rd_mux = (addr == `REG_CTRL) ? {21'h0, ctrl_r} :
                       (addr == `REG_PAR) ? {18'h0, g2_r, 2'b00, g1_r} :
                       (addr == `REG_STAT) ? stat_w : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RST;
      g1_r <= `GAIN_RST;
      g2_r <= `GAIN_RST;
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= rd_stb ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_r <= wdata[`CTRL_W-1:0];
      end
      if (wr_par) begin
        g1_r <= wdata[5:0];
        g2_r <= wdata[13:8];
      end
    end
  end

  // ********************
  // gain hold strobe
  // ********************
  // hold low long enough on capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hcnt_r <= 16'h0000;
      hold_r <= 2'b00;
    end else if (clk_en) begin
      hcnt_r <= wr_par ? 16'(LAT_W) : (hold_busy ? hcnt_r - 16'h0001 : hcnt_r);
      hold_r <= ctrl_r[`CTRL_HOLD +: 2] & {2{~hold_busy}};
    end
  end

  // ********************
  // step pulses
  // ********************
  logic [15:0] pcnt_r;
  logic [3:0] step_n_r;

  // low width then gap before next
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pls_st_r <= PLS_IDLE;
      pcnt_r <= 16'h0000;
      step_n_r <= 4'hf;
    end else if (clk_en) begin
      case (pls_st_r)
        PLS_IDLE: begin
          if (wr_pls && wdata[3:0] != 4'h0) begin
            pls_st_r <= PLS_LOW;
            pcnt_r <= 16'(PLS_W - 1);
            step_n_r <= ~wdata[3:0];
          end
        end
        PLS_LOW: begin
          pcnt_r <= pcnt_r - 16'h0001;
          if (pcnt_r == 16'h0000) begin
            pls_st_r <= PLS_GAP;
            pcnt_r <= 16'(GAP_W - 1);
            step_n_r <= 4'hf;
          end
        end
        PLS_GAP: begin
          pcnt_r <= pcnt_r - 16'h0001;
          if (pcnt_r == 16'h0000) begin
            pls_st_r <= PLS_IDLE;
          end
        end
        default: begin
          pls_st_r <= PLS_IDLE;
        end
      endcase
    end
  end

  // ********************
  // serial frames
  // ********************
  logic sdo_s;
  logic [4:0] bcnt_r;
  logic [15:0] sh_r;
  logic cs_n_r;
  logic sdi_r;

  sync2 #(.W(1)) u_sdo_sync (
    .clk(mclk),
    .en(clk_en),
    .d(link.sdo),
    .q(sdo_s)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      spi_st_r <= SPI_IDLE;
      bcnt_r <= 5'h00;
      sh_r <= 16'h0000;
      cs_n_r <= 1'b1;
      sdi_r <= 1'b0;
      rx_r <= 8'h00;
    end else if (clk_en) begin
      case (spi_st_r)
        SPI_IDLE: begin
          if (wr_spi) begin
            spi_st_r <= SPI_XFER;
            sh_r <= wdata[15:0];
            bcnt_r <= 5'h00;
          end
        end
        SPI_XFER: begin
          if (fall_ev && bcnt_r == `FRM_BITS) begin
            cs_n_r <= 1'b1;
            spi_st_r <= SPI_GAP;
            bcnt_r <= 5'h00;
          end else if (fall_ev) begin
            cs_n_r <= 1'b0;
            sdi_r <= sh_r[15];
            sh_r <= {sh_r[14:0], 1'b0};
          end
          if (rise_ev && !cs_n_r) begin
            bcnt_r <= bcnt_r + 5'h01;
          end
          // sample a full period after launch, past the synchroniser
          if (fall_ev && !cs_n_r) begin
            rx_r <= {rx_r[6:0], sdo_s};
          end
        end
        SPI_GAP: begin
          if (rise_ev) begin
            bcnt_r <= bcnt_r + 5'h01;
          end
          if (fall_ev && bcnt_r >= `TIAG_SCLK) begin
            spi_st_r <= SPI_IDLE;
          end
        end
        default: begin
          spi_st_r <= SPI_IDLE;
        end
      endcase
    end
  end

  // ********************
  // pin drive
  // ********************
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.sdi = sdi_r;
  assign link.mode_lo_drv = ctrl_r[`CTRL_MODE_LO];
  assign link.mode_hi_drv = ctrl_r[`CTRL_MODE_HI];
  assign link.mode_lo_oe = ~ctrl_r[`CTRL_FLOAT];
  assign link.mode_hi_oe = ~ctrl_r[`CTRL_FLOAT];
  assign link.ch1_on = ctrl_r[`CTRL_ON];
  assign link.ch2_on = ctrl_r[`CTRL_ON + 1];
  assign link.ch1_stepsize_lo = ctrl_r[`CTRL_STEP];
  assign link.ch1_stepsize_hi = ctrl_r[`CTRL_STEP + 1];
  assign link.ch2_stepsize_lo = ctrl_r[`CTRL_STEP + 2];
  assign link.ch2_stepsize_hi = ctrl_r[`CTRL_STEP + 3];
  assign link.ch1_hold_gain = hold_r[0];
  assign link.ch2_hold_gain = hold_r[1];
  assign link.ch1_step_up = step_n_r[0];
  assign link.ch1_step_down = step_n_r[1];
  assign link.ch2_step_up = step_n_r[2];
  assign link.ch2_step_down = step_n_r[3];
  assign link.ch1_gain = g1_r;
  assign link.ch2_gain = g2_r;
endmodule
`default_nettype wire

//--- src/dvga_map.svh
// dvga_map.svh: offsets, fields, reset values and timing of the gain-control pair
// assumes an 8 ns controller clock; included by bare name
`ifndef DVGA_MAP_SVH
`define DVGA_MAP_SVH

// ********************
// controller register offsets
// ********************
`define REG_CTRL 8'h00
`define REG_PAR 8'h04
`define REG_PULSE 8'h08
`define REG_SPI 8'h0c
`define REG_STAT 8'h10

// ********************
// control register fields
// ********************
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_FLOAT 2
`define CTRL_ON 3
`define CTRL_HOLD 5
`define CTRL_STEP 7
`define CTRL_W 11
`define CTRL_RST 11'h01f

// ********************
// serial frame
// ********************
`define FRM_RD 15
`define FRM_CH 14
`define FRM_BITS 5'h10

// ********************
// gain codes and step sizes, half-dB units
// ********************
`define GAIN_RST 6'h00
`define GAIN_MAX 6'h00
`define GAIN_MIN 6'h3f
`define STEP_0P5 6'h01
`define STEP_1 6'h02
`define STEP_2 6'h04
`define STEP_6 6'h0c

// ********************
// timing
// ********************
`define MCLK_NS 8
`define TLP_NS 7
`define TPG_NS 20
`define TPW_NS 20
`define TIAG_SCLK 5'h03
`define SCLK_DIV 12
`define DEV_SCLKS 4
`define NS2CYC(ns) (((ns) + `MCLK_NS - 1) / `MCLK_NS)
`define TLP_CYC `NS2CYC(`TLP_NS)
`define TPG_CYC `NS2CYC(`TPG_NS)
`define TPW_CYC `NS2CYC(`TPW_NS)

`endif

//--- src/dvga_pkg.sv
// dvga_pkg.sv: mode type for the device end, state types for the controller end
// assumes nothing beyond the map header
package dvga_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_PULSE = 2'b01,
    MODE_SERIAL = 2'b10,
    MODE_PARALLEL = 2'b11
  } mode_t;
  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_XFER = 3'b010,
    SPI_GAP = 3'b100
  } spi_st_t;
  typedef enum logic [2:0] {
    PLS_IDLE = 3'b001,
    PLS_LOW = 3'b010,
    PLS_GAP = 3'b100
  } pls_st_t;
endpackage

//--- src/dvga_link_if.sv
// dvga_link_if.sv: pins between controller and gain-control device
// assumes the controller makes the serial clock
`timescale 1ns/1ns
`default_nettype none
interface dvga_link_if;
  // serial port
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic sdo;
  // mode pins, driven or released
  logic mode_lo_drv;
  logic mode_lo_oe;
  logic mode_hi_drv;
  logic mode_hi_oe;
  logic mode_sel_lo;
  logic mode_sel_hi;
  // channel pins
  logic ch1_on;
  logic ch2_on;
  logic ch1_hold_gain;
  logic ch2_hold_gain;
  logic ch1_step_up;
  logic ch2_step_up;
  logic ch1_step_down;
  logic ch2_step_down;
  logic ch1_stepsize_lo;
  logic ch1_stepsize_hi;
  logic ch2_stepsize_lo;
  logic ch2_stepsize_hi;
  logic [5:0] ch1_gain;
  logic [5:0] ch2_gain;

  assign mode_sel_lo = mode_lo_oe ? mode_lo_drv : 1'b1;
  assign mode_sel_hi = mode_hi_oe ? mode_hi_drv : 1'b1;
  assign sdo = sdo_oe ? sdo_out : 1'b0;

  modport host_mp (
    output sclk, cs_n, sdi, mode_lo_drv, mode_lo_oe, mode_hi_drv, mode_hi_oe,
    output ch1_on, ch2_on, ch1_hold_gain, ch2_hold_gain, ch1_step_up, ch2_step_up,
    output ch1_step_down, ch2_step_down, ch1_stepsize_lo, ch1_stepsize_hi,
    output ch2_stepsize_lo, ch2_stepsize_hi, ch1_gain, ch2_gain,
    input sdo
  );
  modport dev_mp (
    input sclk, cs_n, sdi, mode_sel_lo, mode_sel_hi,
    input ch1_on, ch2_on, ch1_hold_gain, ch2_hold_gain, ch1_step_up, ch2_step_up,
    input ch1_step_down, ch2_step_down, ch1_stepsize_lo, ch1_stepsize_hi,
    input ch2_stepsize_lo, ch2_stepsize_hi, ch1_gain, ch2_gain,
    output sdo_out, sdo_oe
  );
endinterface
`default_nettype wire

//--- src/sync2.sv
// sync2.sv: two-flop synchroniser for a vector of levels
// assumes each bit is an independent level
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  input wire logic en,
  // levels
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- src/dvga_gain_control.sv
// dvga_gain_control.sv: device end, gain state of two channels
// assumes the link interface and a serial clock that runs while settings change
`timescale 1ns/1ns
`default_nettype none
`include "dvga_map.svh"

// Contract
// - open mode inputs read as high
// - per-channel enable, high means enabled
// - code is attenuation, zero is maximum
// - binary weights 0.5dB up to 16dB
// - host holds gain hold low 7ns
// - host spaces step pulses 20ns apart
// - host serial clock duty 40 to 60
// - data out released after select rises
// - data out driven on falling clock
// - host select 10ns around rising clock
// - host idles select three clocks between
// - hold high freezes, low is transparent
// - mode high-low selects serial port
// - low pulse steps; both restore maximum
// - step size codes 0.5, 1, 2, 6dB
module dvga_gain_control (
  // link to the controller
  dvga_link_if.dev_mp link,
  // control
  input wire logic sys_rst,
  input wire logic clk_en,
  // channel state
  output var logic [5:0] ch1_atten,
  output var logic [5:0] ch2_atten,
  output var logic ch1_active,
  output var logic ch2_active,
  output var dvga_pkg::mode_t mode_now
);
  import dvga_pkg::*;

  // ********************
  // reset, enable and pin synchronisers
  // ********************
  localparam int PW = 26;
  logic [1:0] ctl_s;
  logic [PW-1:0] pin_d;
  logic [PW-1:0] pin_s;
  logic [1:0] mode_s;
  logic [1:0] on_s;
  logic [1:0] hold_s;
  logic [1:0] up_n_s;
  logic [1:0] dn_n_s;
  logic [1:0][1:0] ss_s;
  logic [1:0][5:0] par_s;
  wire rst_s;
  wire en_s;

  sync2 #(.W(2)) u_ctl_sync (
    .clk(link.sclk),
    .en(1'b1),
    .d({sys_rst, clk_en}),
    .q(ctl_s)
  );
  assign rst_s = ctl_s[1];
  assign en_s = ctl_s[0];

  assign pin_d = {link.mode_sel_hi, link.mode_sel_lo,
    link.ch2_on, link.ch1_on,
    link.ch2_hold_gain, link.ch1_hold_gain,
    link.ch2_step_up, link.ch1_step_up,
    link.ch2_step_down, link.ch1_step_down,
    link.ch2_stepsize_hi, link.ch2_stepsize_lo,
    link.ch1_stepsize_hi, link.ch1_stepsize_lo,
    link.ch2_gain, link.ch1_gain};

  sync2 #(.W(PW)) u_pin_sync (
    .clk(link.sclk),
    .en(en_s),
    .d(pin_d),
    .q(pin_s)
  );
  assign {mode_s, on_s, hold_s, up_n_s, dn_n_s, ss_s, par_s} = pin_s;

  // ********************
  // mode decode
  // ********************
  mode_t mode_w;
  assign mode_w = mode_t'(mode_s);
  assign mode_now = mode_w;

  // ********************
  // serial receive
  // ********************
  logic [3:0] bit_r;
  logic [14:0] shf_r;
  logic [1:0] cmd_r;
  wire [15:0] ser_word;
  wire ser_wr;
  wire ser_ch;

  assign ser_word = {shf_r, link.sdi};
  assign ser_wr = ~link.cs_n & (bit_r == 4'hf) & ~ser_word[`FRM_RD];
  assign ser_ch = ser_word[`FRM_CH];

  always_ff @(posedge link.sclk) begin
    if (rst_s) begin
      bit_r <= 4'h0;
      shf_r <= 15'h0000;
      cmd_r <= 2'b00;
    end else if (en_s) begin
      if (link.cs_n) begin
        bit_r <= 4'h0;
      end else begin
        bit_r <= bit_r + 4'h1;
        shf_r <= ser_word[14:0];
      end
      if (~link.cs_n && bit_r == 4'h7) begin
        cmd_r <= shf_r[6:5];
      end
    end
  end

  // ********************
  // serial readback
  // ********************
  wire [5:0] gain_w [2];
  wire [7:0] rb_byte;
  wire rd_bit;
  logic oe_r;
  logic sdo_r;

  assign rb_byte = {2'b00, gain_w[cmd_r[0]]};
  assign rd_bit = cmd_r[1] & bit_r[3] & rb_byte[~bit_r[2:0]];

  // drive and update on falling clock
  always_ff @(negedge link.sclk) begin
    if (rst_s) begin
      oe_r <= 1'b0;
      sdo_r <= 1'b0;
    end else if (en_s) begin
      oe_r <= ~link.cs_n;
      sdo_r <= rd_bit;
    end
  end

  assign link.sdo_out = sdo_r;
  assign link.sdo_oe = oe_r & ~link.cs_n;

  // ********************
  // per-channel gain state
  // ********************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [5:0] gain_r;
    logic [5:0] gain_nxt;
    logic [5:0] stp;
    logic [6:0] sum;
    logic up_d_r;
    logic dn_d_r;
    wire up_ev;
    wire dn_ev;
    wire both;
    wire ser_hit;

    assign up_ev = up_d_r & ~up_n_s[c];
    assign dn_ev = dn_d_r & ~dn_n_s[c];
    assign both = (up_ev & ~dn_n_s[c]) | (dn_ev & ~up_n_s[c]);
    assign ser_hit = ser_wr & (ser_ch == 1'(c));
    assign gain_w[c] = gain_r;

    assign stp = (ss_s[c] == 2'b00) ? `STEP_0P5 :
                 (ss_s[c] == 2'b01) ? `STEP_1 :
                 (ss_s[c] == 2'b10) ? `STEP_2 : `STEP_6;
    assign sum = {1'b0, gain_r} + {1'b0, stp};

    always_comb begin
      gain_nxt = gain_r;
      case (mode_w)
        MODE_PARALLEL: begin
          gain_nxt = par_s[c];
        end
        MODE_SERIAL: begin
          if (ser_hit) begin
            gain_nxt = ser_word[5:0];
          end
        end
        MODE_PULSE: begin
          if (both) begin
            gain_nxt = `GAIN_MAX;
          end else if (up_ev) begin
            gain_nxt = (gain_r > stp) ? gain_r - stp : `GAIN_MAX;
          end else if (dn_ev) begin
            gain_nxt = sum[6] ? `GAIN_MIN : sum[5:0];
          end
        end
        default: begin
          gain_nxt = gain_r;
        end
      endcase
      if (hold_s[c]) begin
        gain_nxt = gain_r;
      end
    end

    always_ff @(posedge link.sclk) begin
      if (rst_s) begin
        gain_r <= `GAIN_RST;
        up_d_r <= 1'b1;
        dn_d_r <= 1'b1;
      end else if (en_s) begin
        gain_r <= gain_nxt;
        up_d_r <= up_n_s[c];
        dn_d_r <= dn_n_s[c];
      end
    end
  end

  // ********************
  // channel outputs
  // ********************
  // attenuation below maximum
  assign ch1_atten = gain_w[0];
  assign ch2_atten = gain_w[1];
  assign ch1_active = on_s[0];
  assign ch2_active = on_s[1];
endmodule
`default_nettype wire

//--- tb/dvga_link_asserts.sv
// dvga_link_asserts.sv: concurrent checks on the controller-to-device link
// assumes sclk is made from mclk by DIV and both ends reset by sys_rst
`timescale 1ns/1ns
`default_nettype none
module dvga_link_asserts #(
  parameter int DIV = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  // mode pins
  input wire logic mode_lo_drv,
  input wire logic mode_lo_oe,
  input wire logic mode_hi_drv,
  input wire logic mode_hi_oe,
  input wire logic mode_sel_lo,
  input wire logic mode_sel_hi,
  // channel one pins
  input wire logic ch1_hold_gain,
  input wire logic ch1_step_up,
  input wire logic ch1_step_down
);
  logic sclk_r;
  logic [7:0] phase_r;
  logic [1:0] gap_r;
  wire logic sclk_rise;
  assign sclk_rise = sclk & ~sclk_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ********************
  // helpers: phase length, idle rises
  // ********************
  always_ff @(posedge mclk) begin
    sclk_r <= sclk;
    phase_r <= (sclk != sclk_r) ? 8'h01 : phase_r + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gap_r <= 2'h3;
    end else if (!cs_n) begin
      gap_r <= 2'h0;
    end else if (sclk_rise && gap_r != 2'h3) begin
      gap_r <= gap_r + 2'h1;
    end
  end
  // ********************
  // assertions
  // ********************
  a_mode_lo_pull: assert property (
    mode_sel_lo == (mode_lo_oe ? mode_lo_drv : 1'b1)) else $error("mode lo level wrong");
  a_mode_hi_pull: assert property (
    mode_sel_hi == (mode_hi_oe ? mode_hi_drv : 1'b1)) else $error("mode hi level wrong");
  a_sdo_released: assert property (
    cs_n |-> !sdo_oe) else $error("data out driven while deselected");
  a_sdo_launch: assert property (
    $rose(sdo_oe) |-> $fell(sclk)) else $error("data out driven off a falling clock");
  a_sdo_update: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> $fell(sclk))
    else $error("data out changed off a falling clock");
  a_select_gap: assert property (
    $fell(cs_n) |-> gap_r == 2'h3) else $error("select gap under three clocks");
  a_select_edge: assert property (
    $changed(cs_n) |-> $fell(sclk)) else $error("select moved near rising clock");
  a_sclk_high: assert property (
    (sclk_r && !sclk) |-> phase_r == 8'(DIV / 2)) else $error("serial clock duty wrong");
  a_hold_low: assert property (
    $fell(ch1_hold_gain) |-> !ch1_hold_gain [*8]) else $error("hold low pulse too short");
  a_up_gap: assert property (
    $rose(ch1_step_up) |-> ch1_step_up [*3]) else $error("step up gap too short");
  a_down_gap: assert property (
    $rose(ch1_step_down) |-> ch1_step_down [*3]) else $error("step down gap too short");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench for the controller and device pair
// assumes the design under src/ and the link checker beside this bench
`timescale 1ns/1ns
`default_nettype none
`include "dvga_map.svh"
module tb_top;
  import dvga_pkg::*;
  localparam int DIV = 4;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [5:0] a1;
  logic [5:0] a2;
  logic act1;
  logic act2;
  mode_t mode_now;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int ex;
  int s;
  logic [11:0] rows [4] = '{12'h03f, 12'hfc0, 12'h56a, 12'h060};
  logic [5:0] steps [4] = '{`STEP_0P5, `STEP_1, `STEP_2, `STEP_6};
  always #4 mclk = ~mclk;
  // ********************
  // design pair and checker
  // ********************
  dvga_link_if lnk ();
  dvga_ctrl_host #(.DIV(DIV)) i_dvga_ctrl_host (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .link(lnk));
  dvga_gain_control i_dvga_gain_control (.link(lnk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ch1_atten(a1), .ch2_atten(a2), .ch1_active(act1), .ch2_active(act2),
    .mode_now(mode_now));
  dvga_link_asserts #(.DIV(DIV)) i_dvga_link_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .sdo_out(lnk.sdo_out), .sdo_oe(lnk.sdo_oe),
    .mode_lo_drv(lnk.mode_lo_drv), .mode_lo_oe(lnk.mode_lo_oe),
    .mode_hi_drv(lnk.mode_hi_drv), .mode_hi_oe(lnk.mode_hi_oe),
    .mode_sel_lo(lnk.mode_sel_lo), .mode_sel_hi(lnk.mode_sel_hi),
    .ch1_hold_gain(lnk.ch1_hold_gain), .ch1_step_up(lnk.ch1_step_up),
    .ch1_step_down(lnk.ch1_step_down));
  // ********************
  // tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_stb <= we;
    rd_stb <= ~we;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic idle();
    for (int i = 0; i < 500; i++) begin
      bus(1'b0, `REG_STAT, 32'h0000_0000);
      if (v[1:0] === 2'b00) break;
    end
  endtask
  task automatic look(input logic [5:0] e1, input logic [5:0] e2, input logic o1,
    input logic o2, input mode_t m);
    for (int i = 0; i < 300; i++) begin
      if (a1 === e1 && a2 === e2 && act1 === o1 && act2 === o2 && mode_now === m) break;
      @(posedge mclk);
    end
    chk("ch1 atten", {26'h0, a1}, {26'h0, e1});
    chk("ch2 atten", {26'h0, a2}, {26'h0, e2});
    chk("enables", {30'h0, act1, act2}, {30'h0, o1, o2});
    chk("mode", {30'h0, mode_now}, {30'h0, m});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (5 * DIV) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, `REG_CTRL, 32'h0000_0000);
    chk("ctrl reset", v, {21'h0, `CTRL_RST});
    look(`GAIN_RST, `GAIN_RST, 1'b1, 1'b1, MODE_PARALLEL);
    foreach (rows[i]) begin
      bus(1'b1, `REG_PAR, {18'h0_0000, rows[i][5:0], 2'b00, rows[i][11:6]});
      look(rows[i][11:6], rows[i][5:0], 1'b1, 1'b1, MODE_PARALLEL);
    end
    bus(1'b1, `REG_CTRL, 32'h0000_0014);
    look(6'h01, 6'h20, 1'b0, 1'b1, MODE_PARALLEL);
    bus(1'b1, `REG_CTRL, 32'h0000_000c);
    look(6'h01, 6'h20, 1'b1, 1'b0, MODE_PARALLEL);
    bus(1'b1, 8'h14, 32'hffff_ffff);
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", v, 32'h0000_0000);
    bus(1'b0, `REG_CTRL, 32'h0000_0000);
    chk("ctrl kept", v, 32'h0000_000c);
    // serial mode, ch1 frozen
    bus(1'b1, `REG_CTRL, 32'h0000_003a);
    bus(1'b1, `REG_PAR, 32'h0000_0707);
    bus(1'b1, `REG_SPI, 32'h0000_0011);
    idle();
    bus(1'b1, `REG_SPI, 32'h0000_402a);
    idle();
    look(6'h01, 6'h2a, 1'b1, 1'b1, MODE_SERIAL);
    bus(1'b1, `REG_SPI, 32'h0000_c000);
    idle();
    chk("serial read", {24'h0, v[15:8]}, 32'h0000_002a);
    bus(1'b1, `REG_CTRL, 32'h0000_001a);
    bus(1'b1, `REG_SPI, 32'h0000_0011);
    idle();
    look(6'h11, 6'h2a, 1'b1, 1'b1, MODE_SERIAL);
    // pulse mode, every step size, clamp at minimum
    bus(1'b1, `REG_CTRL, 32'h0000_0019);
    look(6'h11, 6'h2a, 1'b1, 1'b1, MODE_PULSE);
    bus(1'b1, `REG_PULSE, 32'h0000_0003);
    idle();
    look(`GAIN_MAX, 6'h2a, 1'b1, 1'b1, MODE_PULSE);
    ex = 0;
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? i : 3;
      ex = (ex + steps[s] > 63) ? 63 : ex + steps[s];
      bus(1'b1, `REG_CTRL, 32'h0000_0019 | (s << 7));
      bus(1'b1, `REG_PULSE, 32'h0000_0002);
      idle();
      look(ex[5:0], 6'h2a, 1'b1, 1'b1, MODE_PULSE);
    end
    bus(1'b1, `REG_PULSE, 32'h0000_0001);
    idle();
    look(6'h33, 6'h2a, 1'b1, 1'b1, MODE_PULSE);
    bus(1'b1, `REG_PULSE, 32'h0000_0003);
    idle();
    bus(1'b1, `REG_PULSE, 32'h0000_0001);
    idle();
    look(`GAIN_MAX, 6'h2a, 1'b1, 1'b1, MODE_PULSE);
    end_sim();
  end
endmodule
`default_nettype wire
